// ===== logic/flash_host_ctl.sv
// APB-controlled host engine that drives a parallel NOR flash through its pins
// Functional notes
// - Separate active-low select, write, output enable
// - Commands are plain write cycles to flash
// - Erase suspend and resume by host command
// - Unlock bypass allows shortened program sequences
// - Deselected flash enters standby, reselect reads
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module flash_host_ctl #(
    parameter int                RST_PULSE_CYC = 25,
    parameter logic [`TMO_W-1:0] TIMEOUT_CYC   = 24'hFFFFFF
) (
    // Clock and reset
    input  wire logic                  clk_sys_in,
    input  wire logic                  nrst_in,
    // APB slave
    input  wire logic                  psel_in,
    input  wire logic                  penable_in,
    input  wire logic                  pwrite_in,
    input  wire logic [7:0]            paddr_in,
    input  wire logic [31:0]           pwdata_in,
    output logic      [31:0]           prdata_out,
    output logic                       pready_out,
    output logic                       pslverr_out,
    // Interrupt
    output logic                       irq_out,
    // Flash pins
    output logic      [`FL_ADDR_W-1:0] fl_addr_out,
    input  wire logic [`FL_DATA_W-1:0] byte_data_lines_in,
    output logic      [`FL_DATA_W-1:0] byte_data_lines_out,
    output logic                       byte_data_lines_oe_out,
    output logic                       fl_ce_n_out,
    output logic                       fl_we_n_out,
    output logic                       fl_oe_n_out,
    output logic                       fl_reset_n_out,
    input  wire logic                  op_done_indicator_n_in
);
    localparam logic [`CNT_W-1:0] ACC_C = `CNT_W'(`ACC_CYC);
    localparam logic [`CNT_W-1:0] RD_C  = `CNT_W'(`ACC_CYC + `SYNC_LAT);
    localparam logic [`CNT_W-1:0] RST_C = `CNT_W'(RST_PULSE_CYC);

    flash_ctl_pkg::st_s st_r;
    flash_ctl_pkg::st_s st_nxt;

    logic [`FL_DATA_W:0] sync_q;
    logic [`FL_DATA_W-1:0] dq_s;
    logic                rdy_s;
    logic                apb_wr;
    logic                apb_rd;
    logic                mapped;
    logic [`INT_W-1:0]   ev;

    pin_sync #(
        .W       (`FL_DATA_W + 1),
        .RST_VAL ('1)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .nrst_in    (nrst_in),
        .pins_in    ({op_done_indicator_n_in, byte_data_lines_in}),
        .pins_out   (sync_q)
    );
    assign dq_s  = sync_q[`FL_DATA_W-1:0];
    assign rdy_s = sync_q[`FL_DATA_W];

    assign apb_wr = psel_in && penable_in && pwrite_in;
    assign apb_rd = psel_in && penable_in && !pwrite_in;
    assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= `REG_CFG);

    always_comb begin
        st_nxt = st_r;
        ev     = '0;
        if (st_r.tmo != '0) begin
            st_nxt.tmo = st_r.tmo - `TMO_W'(1);
        end
        if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - `CNT_W'(1);
        end
        st_nxt.rdy_prev = rdy_s;
        ev[`INT_RDY] = rdy_s && !st_r.rdy_prev;
        if (apb_wr) begin
            case (paddr_in)
                `REG_ADDR:     st_nxt.addr_reg = pwdata_in[`FL_ADDR_W-1:0];
                `REG_WDATA:    st_nxt.wdata_reg = pwdata_in[`FL_DATA_W-1:0];
                `REG_INT_MASK: st_nxt.int_mask = pwdata_in[`INT_W-1:0];
                `REG_CFG:      st_nxt.keep_sel = pwdata_in[`CFG_KEEP_SEL];
                default: ;
            endcase
        end
        case (st_r.state)
            flash_ctl_pkg::S_IDLE: begin
                st_nxt.pin.we_n  = 1'b1;
                st_nxt.pin.oe_n  = 1'b1;
                st_nxt.pin.dq_oe = 1'b0;
                st_nxt.pin.rst_n = 1'b1;
                // Deselecting between operations puts the flash in standby
                st_nxt.pin.ce_n  = !st_r.keep_sel;
                if (apb_wr && paddr_in == `REG_CTRL) begin
                    st_nxt.op       = pwdata_in[`OP_W-1:0];
                    st_nxt.tmo      = TIMEOUT_CYC;
                    st_nxt.tmo_flag = 1'b0;
                    st_nxt.first    = 1'b1;
                    st_nxt.busy     = 1'b1;
                    st_nxt.pin.addr = st_r.addr_reg;
                    st_nxt.pin.dq   = st_r.wdata_reg;
                    case (pwdata_in[`OP_W-1:0])
                        `OP_WRITE, `OP_READ, `OP_POLL: st_nxt.state = flash_ctl_pkg::S_SETUP;
                        `OP_RESET: begin
                            st_nxt.state     = flash_ctl_pkg::S_RSTP;
                            st_nxt.pin.rst_n = 1'b0;
                            st_nxt.pin.ce_n  = 1'b1;
                            st_nxt.cnt       = RST_C - `CNT_W'(1);
                        end
                        `OP_WAIT_RDY: begin
                            st_nxt.state = flash_ctl_pkg::S_WAIT;
                            st_nxt.cnt   = `CNT_W'(`SETTLE_CYC);
                        end
                        default: begin
                            st_nxt.busy = 1'b0;
                            ev[`INT_REFUSED] = 1'b1;
                        end
                    endcase
                end
            end
            flash_ctl_pkg::S_SETUP: begin
                st_nxt.pin.ce_n = 1'b0;
                st_nxt.state    = flash_ctl_pkg::S_PULSE;
                if (st_r.op == `OP_WRITE) begin
                    // Suspend, resume, bypass and unlock steps all leave as plain writes
                    st_nxt.pin.we_n  = 1'b0;
                    st_nxt.pin.dq_oe = 1'b1;
                    st_nxt.cnt       = ACC_C - `CNT_W'(1);
                end else begin
                    st_nxt.pin.oe_n = 1'b0;
                    st_nxt.cnt      = RD_C - `CNT_W'(1);
                end
            end
            flash_ctl_pkg::S_PULSE: begin
                if (st_r.cnt == '0) begin
                    st_nxt.pin.we_n = 1'b1;
                    st_nxt.pin.oe_n = 1'b1;
                    st_nxt.state    = flash_ctl_pkg::S_REC;
                    if (st_r.op != `OP_WRITE) begin
                        st_nxt.rdata = dq_s;
                    end
                end
            end
            flash_ctl_pkg::S_REC: begin
                // Data stays driven one cycle past the write strobe for hold time
                st_nxt.pin.dq_oe = 1'b0;
                st_nxt.state     = flash_ctl_pkg::S_IDLE;
                st_nxt.busy      = 1'b0;
                ev[`INT_DONE]    = 1'b1;
                if (st_r.op == `OP_POLL) begin
                    st_nxt.prev  = st_r.rdata;
                    st_nxt.first = 1'b0;
                    if (!st_r.first && st_r.rdata[`FL_TOGGLE_BIT] == st_r.prev[`FL_TOGGLE_BIT]) begin
                        st_nxt.state = flash_ctl_pkg::S_IDLE;
                    end else if (st_r.tmo == '0) begin
                        // A poll that runs out reports the timeout only, never completion
                        st_nxt.tmo_flag = 1'b1;
                        ev[`INT_TMO]    = 1'b1;
                        ev[`INT_DONE]   = 1'b0;
                    end else begin
                        st_nxt.state  = flash_ctl_pkg::S_SETUP;
                        st_nxt.busy   = 1'b1;
                        ev[`INT_DONE] = 1'b0;
                    end
                end
            end
            flash_ctl_pkg::S_RSTP: begin
                if (st_r.cnt == '0) begin
                    st_nxt.pin.rst_n = 1'b1;
                    st_nxt.state     = flash_ctl_pkg::S_IDLE;
                    st_nxt.busy      = 1'b0;
                    ev[`INT_DONE]    = 1'b1;
                end
            end
            flash_ctl_pkg::S_WAIT: begin
                if (st_r.cnt == '0 && (rdy_s || st_r.tmo == '0)) begin
                    st_nxt.state    = flash_ctl_pkg::S_IDLE;
                    st_nxt.busy     = 1'b0;
                    st_nxt.tmo_flag = !rdy_s;
                    ev[`INT_DONE]   = rdy_s;
                    ev[`INT_TMO]    = !rdy_s;
                end
            end
            default: st_nxt.state = flash_ctl_pkg::S_IDLE;
        endcase
        if (apb_wr && paddr_in == `REG_CTRL && st_r.state != flash_ctl_pkg::S_IDLE) begin
            ev[`INT_REFUSED] = 1'b1;
        end
        // A new event beats the clear-on-read in the same cycle
        if (apb_rd && paddr_in == `REG_INT_STAT) begin
            st_nxt.int_stat = ev;
        end else begin
            st_nxt.int_stat = st_r.int_stat | ev;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r           <= '0;
            st_r.state     <= flash_ctl_pkg::S_IDLE;
            st_r.pin.ce_n  <= 1'b1;
            st_r.pin.we_n  <= 1'b1;
            st_r.pin.oe_n  <= 1'b1;
            st_r.pin.rst_n <= 1'b1;
            st_r.rdy_prev  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        prdata_out = 32'h0000_0000;
        case (paddr_in)
            `REG_CTRL:     prdata_out[`OP_W-1:0] = st_r.op;
            `REG_ADDR:     prdata_out[`FL_ADDR_W-1:0] = st_r.addr_reg;
            `REG_WDATA:    prdata_out[`FL_DATA_W-1:0] = st_r.wdata_reg;
            `REG_RDATA:    prdata_out[`FL_DATA_W-1:0] = st_r.rdata;
            `REG_STATUS: begin
                prdata_out[`ST_BUSY] = st_r.busy;
                prdata_out[`ST_RDY]  = rdy_s;
                prdata_out[`ST_TMO]  = st_r.tmo_flag;
                prdata_out[`ST_SECT_MSB:`ST_SECT_LSB] = st_r.addr_reg[`FL_SECT_MSB:`FL_SECT_LSB];
            end
            `REG_INT_STAT: prdata_out[`INT_W-1:0] = st_r.int_stat;
            `REG_INT_MASK: prdata_out[`INT_W-1:0] = st_r.int_mask;
            `REG_CFG:      prdata_out[`CFG_KEEP_SEL] = st_r.keep_sel;
            default: ;
        endcase
    end

    assign pready_out             = 1'b1;
    assign pslverr_out            = psel_in && penable_in && !mapped;
    assign irq_out                = |(st_r.int_stat & st_r.int_mask);
    assign fl_addr_out            = st_r.pin.addr;
    assign byte_data_lines_out    = st_r.pin.dq;
    assign byte_data_lines_oe_out = st_r.pin.dq_oe;
    assign fl_ce_n_out            = st_r.pin.ce_n;
    assign fl_we_n_out            = st_r.pin.we_n;
    assign fl_oe_n_out            = st_r.pin.oe_n;
    assign fl_reset_n_out         = st_r.pin.rst_n;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence write_start_s;
        apb_wr && paddr_in == `REG_CTRL && pwdata_in[`OP_W-1:0] == `OP_WRITE
            && st_r.state == flash_ctl_pkg::S_IDLE;
    endsequence
    sequence setup_then_strobe_s;
        fl_we_n_out ##1 (!fl_ce_n_out && !fl_we_n_out && byte_data_lines_oe_out);
    endsequence

    strobe_excl_a: assert property (!(!fl_we_n_out && !fl_oe_n_out))
        else $error("write and output enable low together");
    no_contend_a: assert property (byte_data_lines_oe_out |-> fl_oe_n_out)
        else $error("bus driven while flash output enabled");
    write_seq_a: assert property (write_start_s |=> setup_then_strobe_s)
        else $error("write cycle did not follow start");
    latch_hold_a: assert property (!fl_we_n_out && $past(!fl_we_n_out)
        |-> $stable(fl_addr_out) && $stable(byte_data_lines_out))
        else $error("address or data moved under write strobe");
    reset_quiet_a: assert property ($fell(fl_reset_n_out) |-> fl_ce_n_out && fl_we_n_out
        ##1 !fl_reset_n_out)
        else $error("reset pulse not clean");
    standby_a: assert property (st_r.state == flash_ctl_pkg::S_IDLE && !st_r.keep_sel
        && !apb_wr |=> fl_ce_n_out)
        else $error("flash left selected while idle");
    wait_done_a: assert property (st_r.state == flash_ctl_pkg::S_WAIT && st_r.cnt == '0 && rdy_s
        |=> !st_r.busy && st_r.int_stat[`INT_DONE])
        else $error("ready pin not reported");
    rdclr_a: assert property (apb_rd && paddr_in == `REG_INT_STAT && st_r.int_stat[`INT_DONE]
        && st_r.state == flash_ctl_pkg::S_IDLE |=> !st_r.int_stat[`INT_DONE])
        else $error("status not cleared by read");
    toggle_stop_a: assert property (st_r.state == flash_ctl_pkg::S_REC && st_r.op == `OP_POLL
        && !st_r.first && st_r.rdata[`FL_TOGGLE_BIT] == st_r.prev[`FL_TOGGLE_BIT]
        |=> st_r.state == flash_ctl_pkg::S_IDLE && st_r.int_stat[`INT_DONE])
        else $error("toggle poll did not finish");
endmodule // flash_host_ctl

// ===== shared/flash_ctl_regs.svh
// Register offsets, field positions and timing figures of the flash host controller
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// Flash geometry
`define FL_ADDR_W      21
`define FL_DATA_W      8
`define FL_SECT_MSB    20
`define FL_SECT_LSB    16
`define FL_POLL_BIT    7
`define FL_TOGGLE_BIT  6

// APB register byte offsets
`define REG_CTRL       8'h00
`define REG_ADDR       8'h04
`define REG_WDATA      8'h08
`define REG_RDATA      8'h0C
`define REG_STATUS     8'h10
`define REG_INT_STAT   8'h14
`define REG_INT_MASK   8'h18
`define REG_CFG        8'h1C

// CTRL operation codes, bits 2:0
`define OP_W           3
`define OP_WRITE       3'h1
`define OP_READ        3'h2
`define OP_POLL        3'h3
`define OP_RESET       3'h4
`define OP_WAIT_RDY    3'h5

// STATUS fields
`define ST_BUSY        0
`define ST_RDY         1
`define ST_TMO         2
`define ST_SECT_LSB    8
`define ST_SECT_MSB    12

// Interrupt bits
`define INT_W          4
`define INT_DONE       0
`define INT_TMO        1
`define INT_RDY        2
`define INT_REFUSED    3

// CFG fields
`define CFG_KEEP_SEL   0

// Timing
`define T_CLK_NS       20
`define T_ACCESS_NS    120
`define ACC_CYC        ((`T_ACCESS_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define SYNC_LAT       4
`define SETTLE_CYC     4
`define CNT_W          16
`define TMO_W          24
`endif

// ===== shared/flash_ctl_pkg.sv
// Types shared by the flash host controller
`include "flash_ctl_regs.svh"
package flash_ctl_pkg;
    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_SETUP = 6'h02,
        S_PULSE = 6'h04,
        S_REC   = 6'h08,
        S_RSTP  = 6'h10,
        S_WAIT  = 6'h20
    } state_e;

    typedef struct packed {
        logic [`FL_ADDR_W-1:0] addr;
        logic [`FL_DATA_W-1:0] dq;
        logic                  dq_oe;
        logic                  ce_n;
        logic                  we_n;
        logic                  oe_n;
        logic                  rst_n;
    } pins_s;

    typedef struct packed {
        state_e                state;
        logic [`CNT_W-1:0]     cnt;
        logic [`TMO_W-1:0]     tmo;
        logic [`OP_W-1:0]      op;
        pins_s                 pin;
        logic [`FL_ADDR_W-1:0] addr_reg;
        logic [`FL_DATA_W-1:0] wdata_reg;
        logic [`FL_DATA_W-1:0] rdata;
        logic [`FL_DATA_W-1:0] prev;
        logic                  first;
        logic                  busy;
        logic                  tmo_flag;
        logic                  rdy_prev;
        logic                  keep_sel;
        logic [`INT_W-1:0]     int_stat;
        logic [`INT_W-1:0]     int_mask;
    } st_s;
endpackage

// ===== logic/pin_sync.sv
// Three-stage synchroniser for flash pins; output moves once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int          W       = 9,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input  wire logic         clk_sys_in,
    input  wire logic         nrst_in,
    // Pins
    input  wire logic [W-1:0] pins_in,
    output logic      [W-1:0] pins_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pins_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Stage one feeds only stage two; the agreement test looks at two and three
        st_nxt.q  = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r <= {4{RST_VAL}};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins_out = st_r.q;
endmodule // pin_sync

// ===== tb/flash_dev_model.sv
// Behavioural parallel NOR flash that answers the host controller's pins
`timescale 1ns/10ps
module flash_dev_model #(
    parameter int         PROG_NS   = 2000,
    parameter int         ERASE_NS  = 10000,
    parameter logic [4:0] PROT_SECT = 5'h1F
) (
    // Flash pins
    input  wire logic [20:0] addr_in,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    input  wire logic        ce_n_in,
    input  wire logic        we_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        reset_n_in,
    input  wire logic        supply_low_in,
    input  wire logic        unprot_in,
    output logic             rdy_out
);
    logic [7:0] mem [0:2097151];
    logic [7:0] last_q;
    logic [7:0] prog_q;
    logic       tog_q;
    int         step;
    realtime    end_t;
    wire        drv = !ce_n_in && !oe_n_in && reset_n_in;
    // A released bus shows the inverse of its last value so a stale byte never looks valid
    assign dq_out = !drv ? ~last_q : !rdy_out ? {~prog_q[7], tog_q, 6'h00} : mem[addr_in];
    initial begin
        last_q = 8'h00;
        prog_q = 8'h00;
        tog_q = 1'b0;
        step = 0;
        rdy_out = 1'b1;
        end_t = 0;
        for (int i = 0; i < 2097152; i++) mem[i] = 8'hFF;
    end
    always @(dq_out) if (drv) last_q = dq_out;
    always @(negedge oe_n_in) if (!rdy_out && !ce_n_in) tog_q = ~tog_q;
    always #10 if (!rdy_out && $realtime >= end_t) rdy_out = 1'b1;
    always @(negedge reset_n_in) begin
        rdy_out = 1'b1;
        step = 0;
    end
    task automatic start(input int ns);
        rdy_out = 1'b0;
        end_t = $realtime + ns;
    endtask
    // Writes latch on the rising strobe; writes while busy are dropped
    always @(posedge we_n_in) begin
        if (!ce_n_in && reset_n_in && rdy_out && !supply_low_in) begin
            case (step)
                0, 3: step = (addr_in == 21'h000555 && dq_in == 8'hAA) ? step + 1 : 0;
                1, 4: step = (addr_in == 21'h0002AA && dq_in == 8'h55) ? step + 1 : 0;
                2: step = dq_in == 8'hA0 ? 6 : dq_in == 8'h80 ? 3 : 0;
                5: begin
                    step = 0;
                    if (dq_in == 8'h30 && (addr_in[20:16] != PROT_SECT || unprot_in)) begin
                        for (int k = 0; k < 65536; k++) mem[{addr_in[20:16], k[15:0]}] = 8'hFF;
                        prog_q = 8'hFF;
                        start(ERASE_NS);
                    end
                end
                default: begin
                    step = 0;
                    if (addr_in[20:16] != PROT_SECT || unprot_in) begin
                        mem[addr_in] = mem[addr_in] & dq_in;
                        prog_q = dq_in;
                        start(PROG_NS);
                    end
                end
            endcase
        end
    end
endmodule // flash_dev_model

// ===== tb/flash_host_ctl_tb_top.sv
// Self-checking bench: APB host controller driving the behavioural flash
`timescale 1ns/10ps
`include "flash_ctl_regs.svh"
module flash_host_ctl_tb_top;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_s;
    logic        clk_sys_in, nrst_in, psel, penable, pwrite;
    logic        pready, pslverr, irq, dq_oe, ce_n, we_n, oe_n, rst_n, rdy, vlow, unprot;
    logic [7:0]  paddr, dq_dev, dq_dut, d;
    logic [31:0] pwdata, prdata, v;
    logic [20:0] fl_addr, a, b;
    wire  [7:0]  dq_line = dq_oe ? dq_dut : dq_dev;
    note_s       q[$];
    note_s       n;
    int          err_count, checks_done, seed;

    flash_host_ctl #(.RST_PULSE_CYC(3), .TIMEOUT_CYC(24'h0000C8)) u_dut (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .fl_addr_out(fl_addr),
        .byte_data_lines_in(dq_line), .byte_data_lines_out(dq_dut), .byte_data_lines_oe_out(dq_oe),
        .fl_ce_n_out(ce_n), .fl_we_n_out(we_n), .fl_oe_n_out(oe_n), .fl_reset_n_out(rst_n),
        .op_done_indicator_n_in(rdy));
    flash_dev_model u_flash (.addr_in(fl_addr), .dq_in(dq_line), .dq_out(dq_dev), .ce_n_in(ce_n),
        .we_n_in(we_n), .oe_n_in(oe_n), .reset_n_in(rst_n), .supply_low_in(vlow), .unprot_in(unprot),
        .rdy_out(rdy));

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    task automatic fail(input string s);
        err_count++;
        $display("CHECK FAILED t=%0t %s", $time, s);
    endtask
    task automatic chk(input logic ok, input string s);
        checks_done++;
        if (ok !== 1'b1) fail(s);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read results are judged here, in the order the driver noted them
    always @(posedge clk_sys_in) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (q.size() == 0) fail("read without note");
            else begin
                n = q.pop_front();
                checks_done++;
                if (((prdata ^ n.d) & n.m) !== 32'h0 || pslverr !== n.e) fail($sformatf("read %h got %h", paddr, prdata));
            end
        end
    end
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do @(posedge clk_sys_in); while (pready !== 1'b1);
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m, input logic e);
        q.push_back(note_s'{ex, m, e});
        apb(1'b0, ad, 32'h0);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            rd(`REG_STATUS, 32'h0, 32'h0, 1'b0);
            k++;
        end while (v[`ST_BUSY] !== 1'b0 && k < 2000);
        chk(k < 2000, "controller stuck busy");
    endtask
    task automatic op(input logic [2:0] c);
        wr(`REG_CTRL, {29'h0, c});
        wait_idle();
    endtask
    task automatic fw(input logic [20:0] ad, input logic [7:0] dd);
        wr(`REG_ADDR, {11'h0, ad});
        wr(`REG_WDATA, {24'h0, dd});
        op(`OP_WRITE);
    endtask
    task automatic fr(input logic [20:0] ad, input logic [7:0] ex, input logic [7:0] m);
        wr(`REG_ADDR, {11'h0, ad});
        op(`OP_READ);
        rd(`REG_RDATA, {24'h0, ex}, {24'h0, m}, 1'b0);
    endtask
    task automatic cmd(input logic [7:0] c);
        fw(21'h000555, 8'hAA);
        fw(21'h0002AA, 8'h55);
        fw(21'h000555, c);
    endtask
    task automatic prog(input logic [20:0] ad, input logic [7:0] dd);
        cmd(8'hA0);
        fw(ad, dd);
        op(`OP_WAIT_RDY);
    endtask

    initial begin
        #800000;
        fail("watchdog expired");
        conclude();
    end
    initial begin
        seed = 32'h0f9e;
        err_count = 0;
        checks_done = 0;
        nrst_in = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        vlow = 1'b0;
        unprot = 1'b0;
        repeat (20) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        @(posedge clk_sys_in);
        for (int i = 0; i < 8; i++) rd(8'(i * 4), i == 4 ? 32'h2 : 32'h0, 32'hFFFFFFFF, 1'b0);
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h0, 32'hFFFFFFFF, 1'b1);
        rd(8'h05, 32'h0, 32'hFFFFFFFF, 1'b1);
        rd(`REG_ADDR, 32'h0, 32'hFFFFFFFF, 1'b0);
        $display("test registers done");
        a = 21'($random(seed)) & 21'h0FFFF0;
        d = 8'($random(seed));
        b = {5'h11, 16'($random(seed))};
        cmd(8'hA0);
        fw(a, d);
        fr(a, ~d, 8'h80);
        op(`OP_WAIT_RDY);
        rd(`REG_STATUS, 32'h2, 32'h7, 1'b0);
        fr(a, d, 8'hFF);
        cmd(8'hA0);
        fw(a + 21'h1, d ^ 8'h5A);
        rd(`REG_INT_STAT, 32'h0, 32'h0, 1'b0);
        op(`OP_POLL);
        rd(`REG_INT_STAT, 32'h1, 32'h3, 1'b0);
        fr(a + 21'h1, d ^ 8'h5A, 8'hFF);
        $display("test program done");
        prog(b, 8'h00);
        cmd(8'h80);
        fw(21'h000555, 8'hAA);
        fw(21'h0002AA, 8'h55);
        fw(a, 8'h30);
        rd(`REG_INT_STAT, 32'h0, 32'h0, 1'b0);
        op(`OP_WAIT_RDY);
        rd(`REG_INT_STAT, 32'h2, 32'h3, 1'b0);
        rd(`REG_STATUS, 32'h4, 32'h5, 1'b0);
        repeat (3) op(`OP_WAIT_RDY);
        rd(`REG_STATUS, 32'h2, 32'h3, 1'b0);
        fr(a, 8'hFF, 8'hFF);
        fr(b, 8'h00, 8'hFF);
        $display("test erase done");
        prog({5'h1F, 16'h0010}, 8'h00);
        fr({5'h1F, 16'h0010}, 8'hFF, 8'hFF);
        fw(21'h000555, 8'hAA);
        fw(21'h0002AA, 8'h12);
        fw(21'h000555, 8'hA0);
        fw(a + 21'h2, 8'h00);
        fr(a + 21'h2, 8'hFF, 8'hFF);
        unprot <= 1'b1;
        prog({5'h1F, 16'h0020}, 8'h00);
        unprot <= 1'b0;
        fr({5'h1F, 16'h0020}, 8'h00, 8'hFF);
        vlow <= 1'b1;
        cmd(8'hA0);
        fw(a + 21'h4, 8'h00);
        vlow <= 1'b0;
        fr(a + 21'h4, 8'hFF, 8'hFF);
        $display("test refusals done");
        cmd(8'hA0);
        fw(a + 21'h3, 8'h00);
        op(`OP_RESET);
        op(`OP_WAIT_RDY);
        rd(`REG_STATUS, 32'h2, 32'h7, 1'b0);
        fr(b, 8'h00, 8'hFF);
        $display("test reset done");
        rd(`REG_INT_STAT, 32'h0, 32'h0, 1'b0);
        wr(`REG_INT_MASK, 32'h9);
        wr(`REG_CTRL, {29'h0, `OP_READ});
        wr(`REG_CTRL, {29'h0, `OP_READ});
        wait_idle();
        chk(irq === 1'b1, "irq not raised");
        rd(`REG_INT_STAT, 32'h9, 32'hF, 1'b0);
        chk(irq === 1'b0, "irq not cleared");
        wr(`REG_CTRL, 32'h7);
        chk(irq === 1'b1, "unknown op not refused");
        rd(`REG_INT_STAT, 32'h8, 32'hF, 1'b0);
        wr(`REG_INT_MASK, 32'h0);
        op(`OP_READ);
        chk(irq === 1'b0, "masked irq raised");
        rd(`REG_INT_STAT, 32'h1, 32'hF, 1'b0);
        wr(`REG_CFG, 32'h1);
        @(posedge clk_sys_in);
        chk(ce_n === 1'b0, "select not kept");
        wr(`REG_CFG, 32'h0);
        @(posedge clk_sys_in);
        chk(ce_n === 1'b1, "standby not entered");
        fr(b, 8'h00, 8'hFF);
        $display("test interrupts done");
        conclude();
    end
endmodule // flash_host_ctl_tb_top
